//--- common/fbmpc_defs.vh
`ifndef FBMPC_DEFS_VH
`define FBMPC_DEFS_VH

// core clock period
`define FBMPC_CLK_PS      4000

// symbol codes at the access sublayer side
`define FBMPC_SYM_W       3
`define FBMPC_SYM_SIL     3'h0
`define FBMPC_SYM_PAD     3'h1
`define FBMPC_SYM_ZERO    3'h2
`define FBMPC_SYM_ONE     3'h3
`define FBMPC_SYM_NDATA   3'h4
`define FBMPC_SYM_BAD     3'h5

// rate select codes
`define FBMPC_RATE_5M     2'h0
`define FBMPC_RATE_10M    2'h1
`define FBMPC_RATE_20M    2'h2

// half-symbol times in ns and their cycle counts (rounded down)
`define FBMPC_HS5_NS      100
`define FBMPC_HS10_NS     50
`define FBMPC_HS20_NS     25
`define FBMPC_HS5_CYC     ((`FBMPC_HS5_NS * 1000) / `FBMPC_CLK_PS)
`define FBMPC_HS10_CYC    ((`FBMPC_HS10_NS * 1000) / `FBMPC_CLK_PS)
`define FBMPC_HS20_CYC    ((`FBMPC_HS20_NS * 1000) / `FBMPC_CLK_PS)

// jabber window in ms and its cycle count
`define FBMPC_JAB_MS      500
`define FBMPC_JAB_CYC     (`FBMPC_JAB_MS * (1000000000 / `FBMPC_CLK_PS))

// silence is reported after this many idle half-symbols (four symbols)
`define FBMPC_SIL_HS      8

// transmit buffer depth
`define FBMPC_FIFO_DEPTH  8

`endif

//--- hdl/fbmpc_fifo.v
`timescale 1ns/1ps
module fbmpc_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  // ready has its own flop so the port is registered, not an inverter
  reg             ready_q;
  wire            push;
  wire            pop;
  wire [AW:0]     cnt_d;

  assign in_ready  = ready_q;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & ready_q;
  assign pop       = out_ready & out_valid;
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge core_clk) begin
    if (rst) begin
      wr_q   <= {AW{1'b0}};
      rd_q   <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != DEPTH);
    end
  end
endmodule // fbmpc_fifo

//--- hdl/fbmpc_codec.v
`timescale 1ns/1ps
`include "fbmpc_defs.vh"
module fbmpc_codec #(
  parameter JAB_CYC = `FBMPC_JAB_CYC,
  parameter DEPTH   = `FBMPC_FIFO_DEPTH
) (
  // clock and reset
  input  wire                    core_clk,
  input  wire                    rst,
  // rate select, steady while running
  input  wire [1:0]              rate_sel,
  // transmit symbols from the access sublayer
  input  wire [`FBMPC_SYM_W-1:0] tx_sym,
  input  wire                    tx_valid,
  output wire                    tx_ready,
  // receive symbols to the access sublayer
  output reg  [`FBMPC_SYM_W-1:0] rx_sym_q,
  output reg                     rx_valid_q,
  output reg                     rx_silent_q,
  // optical transmitter
  output reg                     opt_light_q,
  output reg                     opt_enable_q,
  output reg                     jabber_q,
  // optical receiver, asynchronous
  input  wire                    opt_rx_light,
  input  wire                    opt_rx_energy
);
  // counts are worked out as integers, then cut to the counter widths
  localparam integer HS5_N   = `FBMPC_HS5_CYC;
  localparam integer HS10_N  = `FBMPC_HS10_CYC;
  localparam integer HS20_N  = `FBMPC_HS20_CYC;
  localparam integer JAB_N   = JAB_CYC - 1;
  localparam [4:0]   HS5     = HS5_N[4:0];
  localparam [4:0]   HS10    = HS10_N[4:0];
  localparam [4:0]   HS20    = HS20_N[4:0];
  localparam [3:0]   SIL_HS  = `FBMPC_SIL_HS;
  localparam [26:0]  JAB_LIM = JAB_N[26:0];

  reg [4:0] hs_lim;

  always @* begin
    case (rate_sel)
      `FBMPC_RATE_5M:  hs_lim = HS5;
      `FBMPC_RATE_10M: hs_lim = HS10;
      default:         hs_lim = HS20;
    endcase
  end

  // transmit buffer
  wire [`FBMPC_SYM_W-1:0] f_sym;
  wire                    f_valid;
  wire                    f_pop;

  fbmpc_fifo #(
    .WIDTH (`FBMPC_SYM_W),
    .DEPTH (DEPTH),
    .AW    (3)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (tx_sym),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (f_sym),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // encoder
  reg [4:0]  tcnt_q;
  reg        thalf_q;
  reg        prev_q;
  reg        sec_lvl_q;
  reg        sec_on_q;
  reg        cur_on_q;
  reg        pad_par_q;
  reg        nd_par_q;
  reg        nd_lvl_q;
  reg [26:0] jcnt_q;
  reg        a_lvl;
  reg        b_lvl;
  reg        p_on;
  wire       ttick;
  wire [`FBMPC_SYM_W-1:0] nsym;

  assign ttick = (tcnt_q >= hs_lim - 5'h01);
  // underrun between frames is sent as silence
  assign f_pop = ttick & thalf_q & f_valid;
  assign nsym  = f_valid ? f_sym : `FBMPC_SYM_SIL;

  always @* begin
    a_lvl = 1'b0;
    b_lvl = 1'b0;
    p_on  = 1'b1;
    case (nsym)
      `FBMPC_SYM_ZERO: begin
        a_lvl = 1'b1;
        b_lvl = 1'b0;
      end
      `FBMPC_SYM_ONE: begin
        a_lvl = 1'b0;
        b_lvl = 1'b1;
      end
      `FBMPC_SYM_PAD: begin
        a_lvl = pad_par_q;
        b_lvl = ~pad_par_q;
      end
      `FBMPC_SYM_NDATA: begin
        a_lvl = nd_par_q ? ~nd_lvl_q : prev_q;
        b_lvl = a_lvl;
      end
      default: begin
        p_on = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      tcnt_q       <= 5'h00;
      thalf_q      <= 1'b1;
      prev_q       <= 1'b0;
      sec_lvl_q    <= 1'b0;
      sec_on_q     <= 1'b0;
      cur_on_q     <= 1'b0;
      pad_par_q    <= 1'b0;
      nd_par_q     <= 1'b0;
      nd_lvl_q     <= 1'b0;
      opt_light_q  <= 1'b0;
      opt_enable_q <= 1'b0;
    end else begin
      tcnt_q <= ttick ? 5'h00 : tcnt_q + 5'h01;
      if (ttick) begin
        thalf_q <= ~thalf_q;
        if (thalf_q) begin
          cur_on_q     <= p_on;
          sec_lvl_q    <= b_lvl;
          sec_on_q     <= p_on;
          opt_light_q  <= p_on & a_lvl & ~jabber_q;
          opt_enable_q <= p_on & ~jabber_q;
          if (p_on)
            prev_q <= b_lvl;
          if (nsym == `FBMPC_SYM_PAD)
            pad_par_q <= ~pad_par_q;
          else
            pad_par_q <= 1'b0;
          if (nsym == `FBMPC_SYM_NDATA) begin
            nd_par_q <= ~nd_par_q;
            if (!nd_par_q)
              nd_lvl_q <= prev_q;
          end else begin
            nd_par_q <= 1'b0;
          end
        end else begin
          opt_light_q  <= sec_on_q & sec_lvl_q & ~jabber_q;
          opt_enable_q <= sec_on_q & ~jabber_q;
        end
      end
    end
  end

  // jabber watchdog: counts only while the encoder itself is active
  always @(posedge core_clk) begin
    if (rst) begin
      jcnt_q   <= 27'h0000000;
      jabber_q <= 1'b0;
    end else if (!cur_on_q) begin
      jcnt_q   <= 27'h0000000;
      jabber_q <= 1'b0;
    end else if (jcnt_q >= JAB_LIM) begin
      jabber_q <= 1'b1;
    end else begin
      jcnt_q <= jcnt_q + 27'h0000001;
    end
  end

  // receive synchronisers
  reg       lt_s1_q;
  reg       lt_s2_q;
  reg       lt_s3_q;
  reg       en_s1_q;
  reg       en_s2_q;

  always @(posedge core_clk) begin
    if (rst) begin
      lt_s1_q <= 1'b0;
      lt_s2_q <= 1'b0;
      lt_s3_q <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      lt_s1_q <= opt_rx_light;
      lt_s2_q <= lt_s1_q;
      lt_s3_q <= lt_s2_q;
      en_s1_q <= opt_rx_energy;
      en_s2_q <= en_s1_q;
    end
  end

  // receive recovery and decode
  reg [4:0] rcnt_q;
  reg       rph_q;
  reg       ra_q;
  reg [3:0] idle_q;
  reg       rnd_par_q;
  reg       rnd_lvl_q;
  reg [`FBMPC_SYM_W-1:0] dsym;
  wire      redge;
  wire      rwrap;
  wire      rsamp;
  wire      pair_dn;
  wire      rwake;

  assign redge   = lt_s2_q ^ lt_s3_q;
  assign rwrap   = (rcnt_q >= hs_lim - 5'h01);
  // sample mid half-symbol; edges realign the phase, so jitter stays margin
  assign rsamp   = (rcnt_q == {1'b0, hs_lim[4:1]});
  assign pair_dn = rsamp & rph_q;
  // wake-up restarts the pair phase; a sample on that edge would undo it
  assign rwake   = en_s2_q & rx_silent_q;

  always @* begin
    dsym = `FBMPC_SYM_BAD;
    case ({ra_q, lt_s2_q})
      2'b10: dsym = `FBMPC_SYM_ZERO;
      2'b01: dsym = `FBMPC_SYM_ONE;
      default: begin
        if (!rnd_par_q || (ra_q != rnd_lvl_q))
          dsym = `FBMPC_SYM_NDATA;
      end
    endcase
    if (rnd_par_q && (ra_q != lt_s2_q))
      dsym = `FBMPC_SYM_BAD;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      rcnt_q      <= 5'h00;
      rph_q       <= 1'b0;
      ra_q        <= 1'b0;
      idle_q      <= 4'h0;
      rnd_par_q   <= 1'b0;
      rnd_lvl_q   <= 1'b0;
      rx_sym_q    <= `FBMPC_SYM_SIL;
      rx_valid_q  <= 1'b0;
      rx_silent_q <= 1'b1;
    end else begin
      rx_valid_q <= 1'b0;
      if (redge && !rx_silent_q)
        rcnt_q <= 5'h01;
      else
        rcnt_q <= rwrap ? 5'h00 : rcnt_q + 5'h01;
      if (en_s2_q) begin
        idle_q <= 4'h0;
        if (rx_silent_q) begin
          rx_silent_q <= 1'b0;
          rph_q       <= 1'b0;
          rnd_par_q   <= 1'b0;
          rcnt_q      <= 5'h01;
        end
      end else if (rwrap && idle_q != SIL_HS) begin
        idle_q <= idle_q + 4'h1;
      end else if (idle_q == SIL_HS) begin
        rx_silent_q <= 1'b1;
      end
      if (rsamp && !rwake) begin
        rph_q <= ~rph_q;
        ra_q  <= lt_s2_q;
      end
      // silence keeps the local symbol cadence, so intervals stay bounded
      if (pair_dn && !rwake) begin
        rx_valid_q <= 1'b1;
        if (rx_silent_q) begin
          rx_sym_q <= `FBMPC_SYM_SIL;
        end else begin
          rx_sym_q <= dsym;
          if (dsym == `FBMPC_SYM_NDATA && !rnd_par_q) begin
            rnd_par_q <= 1'b1;
            rnd_lvl_q <= ra_q;
          end else begin
            rnd_par_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule // fbmpc_codec

//--- testbench/fbmpc_codec_assertions.sv
`timescale 1ns/1ps
module fbmpc_chk #(
  parameter JAB_CYC = 2000
) (
  // clock, reset and rate select
  input wire       core_clk,
  input wire       rst,
  input wire [1:0] rate_sel,
  // optical side
  input wire       opt_light_q,
  input wire       opt_enable_q,
  input wire       jabber_q,
  input wire       opt_rx_energy,
  // symbol side
  input wire       rx_silent_q,
  input wire       rx_valid_q
);
  integer   h;
  integer   run_q;
  integer   act_q;
  integer   dark_q;
  integer   gap_q;
  integer   mut_q;
  reg [1:0] prv_q;
  reg       lsil_q;
  always @* h = rate_sel == 2'h0 ? 25 : rate_sel == 2'h1 ? 12 : 6;
  // saturated run after reset so the first change is not judged
  always @(posedge core_clk) begin
    prv_q  <= {opt_light_q, opt_enable_q};
    run_q  <= rst ? 255 : ({opt_light_q, opt_enable_q} != prv_q) ? 0 : run_q + 1;
    act_q  <= (rst || !opt_enable_q) ? 0 : act_q + 1;
    // reset terms keep the counts known from the first edge
    dark_q <= (rst || opt_rx_energy) ? 0 : dark_q + 1;
    gap_q  <= (rst || rx_valid_q) ? 0 : gap_q + 1;
    mut_q  <= (rst || !jabber_q) ? 0 : mut_q + 1;
    lsil_q <= rst ? 1'b1 : rx_valid_q ? rx_silent_q : (lsil_q | rx_silent_q);
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_OFF_DARK: assert property (!opt_enable_q |-> !opt_light_q)
    else $error("light while transmitter off");
  AST_HALF_HOLD: assert property ({opt_light_q, opt_enable_q} != prv_q |-> run_q >= h - 1)
    else $error("half-symbol too short");
  AST_JAB_EARLY: assert property ($rose(jabber_q) |-> act_q >= (JAB_CYC * 3) / 4)
    else $error("inhibit too early");
  AST_JAB_DUE: assert property (act_q >= (JAB_CYC * 5) / 4 |-> jabber_q)
    else $error("inhibit too late");
  AST_JAB_MUTE: assert property (mut_q >= h |-> !opt_enable_q && !opt_light_q)
    else $error("output while inhibited");
  AST_SIL_LATE: assert property ($rose(rx_silent_q) |-> dark_q >= 8 * h - 2)
    else $error("silence reported early");
  AST_SIL_DUE: assert property (dark_q >= 10 * h + 4 |-> rx_silent_q)
    else $error("silence not reported");
  AST_WAKE: assert property (opt_rx_energy [*5] |-> !rx_silent_q)
    else $error("silence while lit");
  AST_GAP: assert property (rx_valid_q && !rx_silent_q && !lsil_q |->
    gap_q + 1 >= (18 * h) / 10 && gap_q + 1 <= (42 * h + 9) / 10)
    else $error("symbol interval out of range");
endmodule // fbmpc_chk

//--- testbench/fbmpc_mac.sv
`timescale 1ns/1ps
`include "fbmpc_defs.vh"
module fbmpc_mac (
  // clock
  input  wire                    core_clk,
  // symbol request
  input  wire                    tx_ready,
  output reg  [`FBMPC_SYM_W-1:0] tx_sym,
  output reg                     tx_valid
);
  initial begin
    tx_sym   = 3'h0;
    tx_valid = 1'b0;
  end
  // ready is a register, so its value at the falling edge holds at the taking edge
  task send(input [2:0] s);
    begin
      @(negedge core_clk);
      tx_sym   = s;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
    end
  endtask
  // released lines show junk, not the last symbol
  task idle;
    begin
      @(negedge core_clk);
      tx_valid = 1'b0;
      tx_sym   = ~tx_sym;
    end
  endtask
endmodule // fbmpc_mac

//--- testbench/fiber_bus_manchester_phy_codec_test.sv
`timescale 1ns/1ps
`include "fbmpc_defs.vh"
module fiber_bus_manchester_phy_codec_test;
  reg        core_clk = 1'b0;
  reg        rst = 1'b1;
  reg  [1:0] rate_sel = 2'h0;
  reg        inj = 1'b0;
  reg        inj_light = 1'b0;
  reg        inj_energy = 1'b0;
  wire [2:0] tx_sym;
  wire [2:0] rx_sym_q;
  wire       tx_valid, tx_ready, rx_valid_q, rx_silent_q;
  wire       opt_light_q, opt_enable_q, jabber_q;
  integer    failures = 0, samples_checked = 0, cyc = 0, seed = 97, i, r, n;
  reg  [3:0] q[$];
  reg  [3:0] e;
  always #2 core_clk = ~core_clk;
  fbmpc_codec #(.JAB_CYC(2000), .DEPTH(8)) u_fbmpc_codec (
    .core_clk(core_clk), .rst(rst), .rate_sel(rate_sel),
    .tx_sym(tx_sym), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_sym_q(rx_sym_q), .rx_valid_q(rx_valid_q), .rx_silent_q(rx_silent_q),
    .opt_light_q(opt_light_q), .opt_enable_q(opt_enable_q), .jabber_q(jabber_q),
    .opt_rx_light(inj ? inj_light : opt_light_q),
    .opt_rx_energy(inj ? inj_energy : opt_enable_q));
  fbmpc_mac u_fbmpc_mac (.core_clk(core_clk), .tx_ready(tx_ready),
    .tx_sym(tx_sym), .tx_valid(tx_valid));
  task check(input [2:0] seen, input [2:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task put(input [2:0] s, input [3:0] x);
    begin
      q.push_back(x);
      u_fbmpc_mac.send(s);
    end
  endtask
  task bit_sym(input b);
    put(b ? `FBMPC_SYM_ONE : `FBMPC_SYM_ZERO, {1'b0, b ? `FBMPC_SYM_ONE : `FBMPC_SYM_ZERO});
  endtask
  task delim(input b);
    begin
      put(`FBMPC_SYM_NDATA, {1'b0, `FBMPC_SYM_NDATA});
      put(`FBMPC_SYM_NDATA, {1'b0, `FBMPC_SYM_NDATA});
      bit_sym(b);
      put(`FBMPC_SYM_NDATA, {1'b0, `FBMPC_SYM_NDATA});
      put(`FBMPC_SYM_NDATA, {1'b0, `FBMPC_SYM_NDATA});
      bit_sym(b);
    end
  endtask
  task wait_sil;
    begin
      n = 0;
      while (rx_silent_q !== 1'b1 && n < 3000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      check({2'b0, rx_silent_q}, 3'h1);
      check({2'b0, q.size() == 0}, 3'h1);
      q.delete();
    end
  endtask
  // last data bit picks the level ahead of the end delimiter
  task frame(input last);
    begin
      for (i = 0; i < 8; i = i + 1)
        put(`FBMPC_SYM_PAD, {1'b1, i[0] ? `FBMPC_SYM_ZERO : `FBMPC_SYM_ONE});
      delim(1'b0);
      for (i = 0; i < 6; i = i + 1)
        bit_sym($random(seed) & 1);
      bit_sym(last);
      delim(1'b1);
      u_fbmpc_mac.idle;
      wait_sil;
    end
  endtask
  // second violation pair at the same level has no inverse
  task inject;
    begin
      q.push_back({1'b0, `FBMPC_SYM_ONE});
      q.push_back({1'b0, `FBMPC_SYM_NDATA});
      q.push_back({1'b0, `FBMPC_SYM_BAD});
      @(negedge core_clk);
      inj = 1'b1;
      inj_energy = 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        inj_light = i != 0;
        repeat (6) @(negedge core_clk);
      end
      inj_energy = 1'b0;
      inj_light = 1'b0;
      wait_sil;
      inj = 1'b0;
    end
  endtask
  // lost training pads are tolerated, nothing else
  always @(negedge core_clk) begin
    if (rx_valid_q === 1'b1 && rx_silent_q === 1'b0 && q.size() > 0) begin
      while (q.size() > 1 && q[0][3] && rx_sym_q === `FBMPC_SYM_NDATA)
        e = q.pop_front();
      e = q.pop_front();
      check(rx_sym_q, e[2:0]);
    end
    cyc = cyc + 1;
    if (cyc > 40000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    for (r = 0; r < 3; r = r + 1) begin
      rst = 1'b1;
      rate_sel = r[1:0];
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      frame(1'b0);
      frame(1'b1);
    end
    inject;
    for (i = 0; i < 220; i = i + 1)
      u_fbmpc_mac.send(`FBMPC_SYM_ONE);
    u_fbmpc_mac.send(`FBMPC_SYM_SIL);
    u_fbmpc_mac.idle;
    check({2'b0, jabber_q}, 3'h1);
    for (n = 0; n < 300 && jabber_q !== 1'b0; n = n + 1)
      @(negedge core_clk);
    check({2'b0, jabber_q}, 3'h0);
    complete_run;
  end
endmodule // fiber_bus_manchester_phy_codec_test
bind fbmpc_codec fbmpc_chk #(.JAB_CYC(JAB_CYC)) u_fbmpc_chk (
  .core_clk(core_clk), .rst(rst), .rate_sel(rate_sel),
  .opt_light_q(opt_light_q), .opt_enable_q(opt_enable_q), .jabber_q(jabber_q),
  .opt_rx_energy(opt_rx_energy), .rx_silent_q(rx_silent_q), .rx_valid_q(rx_valid_q));
